// >>> core/gci_router_pkg.sv
package gci_router_pkg;

  // Port and frame geometry.
  localparam int NPORTS = 3;
  localparam int NBYTES = 32;
  localparam int IDX_W = 5;
  localparam int PORT_W = 2;
  localparam int DATA_W = 32;
  localparam logic [PORT_W-1:0] PORT_LIMIT = 2'h3;
  localparam logic [2:0] ONE_SLOT_LAST = 3'h0;
  localparam logic [2:0] EIGHT_SLOT_LAST = 3'h7;
  localparam logic [4:0] SLOT_LAST_BIT = 5'h1f;
  localparam logic [2:0] BYTE_FIRST_BIT = 3'h0;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  // Byte roles inside one time-slot.
  localparam logic [1:0] BYTE_B1 = 2'h0;
  localparam logic [1:0] BYTE_B2 = 2'h1;
  localparam logic [1:0] BYTE_MON = 2'h2;
  localparam logic [1:0] BYTE_DCI = 2'h3;

  // Fields of the D, C/I and handshake byte.
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [7:0] D_MASK = 8'hc0;
  localparam logic [7:0] CI_MASK = 8'h3c;
  localparam logic [7:0] HS_MASK = 8'h03;
  localparam int CI_LSB = 2;
  localparam int CI_W = 4;
  localparam logic [3:0] WAKE_CODE_DEF = 4'h8;

  // Register map: port, region and word index within the byte address.
  localparam int PADDR_W = 13;
  localparam int IDX_LSB = 2;
  localparam int IDX_TOP = 7;
  localparam int REGION_LSB = 8;
  localparam int REGION_W = 3;
  localparam int PORT_LSB = 11;
  localparam logic [2:0] REG_RX = 3'h0;
  localparam logic [2:0] REG_TX = 3'h1;
  localparam logic [2:0] REG_ROUTE = 3'h2;
  localparam logic [2:0] REG_CTRL = 3'h3;
  localparam logic [4:0] CTRL_IDX = 5'h00;
  localparam logic [4:0] STAT_IDX = 5'h01;

  typedef enum logic [1:0] {
    RM_CPU = 2'b00,
    RM_ROUTE = 2'b01,
    RM_IDLE = 2'b10,
    RM_SPARE = 2'b11
  } route_mode_t;

  typedef struct packed {
    route_mode_t mode;
    logic [1:0] src_port;
    logic [2:0] src_slot;
    logic src_b;
    logic [2:0] fmask;
    logic rsvd;
  } route_t;

  typedef struct packed {
    logic wake;
    logic pll_en;
    logic clk_int;
    logic [2:0] slot_code;
  } port_cfg_t;

  typedef struct packed {
    logic [7:0] frames;
    logic [6:0] rsvd;
    logic locked;
  } stat_t;

  typedef struct packed {
    logic [7:0] rx_byte;
    logic [IDX_W-1:0] rx_idx;
    logic [IDX_W-1:0] tx_idx;
  } link_req_t;

  typedef struct packed {
    logic fsc;
    logic din;
  } gci_in_t;

  typedef struct packed {
    logic dout;
    logic dout_oe_n;
    logic fsc;
    logic fsc_oe_n;
  } gci_out_t;

endpackage : gci_router_pkg

// >>> core/gci_port_link.sv
`timescale 1ns/100ps
`default_nettype none
module gci_port_link
  import gci_router_pkg::*;
(
  // Link clock and reset
  input wire logic link_clk,
  input wire logic presetn,
  // Port pins and frame reference
  input wire gci_in_t pin_in,
  input wire logic ref_fsc,
  output var gci_out_t pin_out,
  // Crossing to the bus domain
  input wire port_cfg_t cfg,
  input wire logic [7:0] ack_byte,
  input wire logic ack_tgl,
  output var link_req_t req,
  output var logic req_tgl,
  output var logic locked
);

  // Next byte index inside the active frame.
  function automatic logic [IDX_W-1:0] step(input logic [IDX_W-1:0] i, input logic [IDX_W-1:0] last);
    step = (i == last) ? '0 : i + 1'b1;
  endfunction : step

  logic rst_s1, rst_s2;
  port_cfg_t cfg_s1, cfg_s2;
  logic ack_s1, ack_s2, ack_s3;
  logic fsc_d, ref_d;
  gci_in_t pin_s1, pin_s2;
  logic ref_s1, ref_s2;
  logic [7:0] pos;
  logic [7:0] rx_sh, tx_sh, tx_next;

  // Reset asserts at once and releases on the link clock.
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // Configuration is quasi-static, so two flops suffice per bit.
  // Pins also pass two flops; data and sync share the delay, so alignment holds.
  always_ff @(posedge link_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      cfg_s1 <= '0;
      cfg_s2 <= '0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      pin_s1 <= '0;
      pin_s2 <= '0;
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      fsc_d <= 1'b0;
      ref_d <= 1'b0;
    end else begin
      cfg_s1 <= cfg;
      cfg_s2 <= cfg_s1;
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      ref_s1 <= ref_fsc;
      ref_s2 <= ref_s1;
      fsc_d <= pin_s2.fsc;
      ref_d <= ref_s2;
    end
  end

  // The clock source decides how many slots the frame holds.
  wire logic [2:0] last_slot = !cfg_s2.clk_int ? cfg_s2.slot_code : // RULE_06 RULE_08
    (cfg_s2.slot_code == ONE_SLOT_LAST) ? ONE_SLOT_LAST : EIGHT_SLOT_LAST; // RULE_07
  wire logic [IDX_W-1:0] last_idx = {last_slot, BYTE_DCI};
  wire logic fsc_rise = pin_s2.fsc & ~fsc_d;
  wire logic ref_rise = ref_s2 & ~ref_d;
  wire logic wrap = pos == {last_slot, SLOT_LAST_BIT};
  // Internal timing free-runs; with tracking on, the line reference realigns it.
  wire logic realign = cfg_s2.clk_int ? (cfg_s2.pll_en & ref_rise) : fsc_rise; // RULE_09 RULE_10
  wire logic [7:0] cur = (realign | wrap) ? '0 : pos + 1'b1; // RULE_13
  wire logic [IDX_W-1:0] done_idx = pos[7:3];
  wire logic load = cur[2:0] == BYTE_FIRST_BIT;
  wire logic out_bit = load ? tx_next[7] : tx_sh[6];
  wire logic ack_ev = ack_s2 ^ ack_s3;

  // Bit position, shifters and open-drain pin drive.
  always_ff @(posedge link_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      pos <= '0;
      rx_sh <= IDLE_BYTE;
      tx_sh <= IDLE_BYTE;
      tx_next <= IDLE_BYTE;
      pin_out <= '{1'b1, 1'b1, 1'b0, 1'b1};
    end else begin
      pos <= cur;
      rx_sh <= {rx_sh[6:0], pin_s2.din};
      tx_sh <= load ? tx_next : {tx_sh[6:0], 1'b1};
      // A late answer leaves the byte at idle rather than repeating old data.
      if (ack_ev) begin
        tx_next <= ack_byte;
      end else if (load) begin
        tx_next <= IDLE_BYTE; // RULE_04
      end
      pin_out.dout <= out_bit;
      pin_out.dout_oe_n <= out_bit;
      pin_out.fsc <= cfg_s2.clk_int & (cur == '0);
      pin_out.fsc_oe_n <= ~cfg_s2.clk_int; // RULE_09
    end
  end

  // Each finished byte goes up with the index of the byte two ahead.
  always_ff @(posedge link_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      req <= '0;
      req_tgl <= 1'b0;
      locked <= 1'b0;
    end else begin
      // The byte is complete only once its last bit has been sampled.
      if (pos[2:0] == BYTE_LAST_BIT) begin
        req <= '{{rx_sh[6:0], pin_s2.din}, done_idx, step(step(done_idx, last_idx), last_idx)}; // RULE_02
        req_tgl <= ~req_tgl;
      end
      if (!(cfg_s2.clk_int & cfg_s2.pll_en)) begin
        locked <= 1'b0;
      end else if (ref_rise) begin
        locked <= wrap; // RULE_10
      end
    end
  end

endmodule : gci_port_link
`default_nettype wire

// >>> core/tri_port_gci_router.sv
// How it works
// RULE_01: Three identical, independent ports.
// RULE_02: Processor reads and writes every frame byte.
// RULE_03: Route any field to same field elsewhere.
// RULE_04: Disabled byte sends all ones.
// RULE_05: Fixed routes repeat every frame unaided.
// RULE_06: External clock: one to eight slots.
// RULE_07: Internal clock: one or eight slots.
// RULE_08: Clock source chosen per port.
// RULE_09: Internal frame generator usable per port.
// RULE_10: Optional tracking locks to line-side timing.
// RULE_11: Line-side transceiver masters timing when active.
// RULE_12: Wake code in C/I starts line timing.
// RULE_13: Slot is B1, B2, monitor, D/CI byte.
`timescale 1ns/100ps
`default_nettype none
module tri_port_gci_router
  import gci_router_pkg::*;
#(
  parameter logic [3:0] WAKE_CODE = WAKE_CODE_DEF
) (
  // Bus clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output var logic pready,
  output var logic [DATA_W-1:0] prdata,
  output var logic pslverr,
  // GCI link, one clock for all three ports
  input wire logic link_clk,
  input wire logic line_ref_fsc,
  input wire gci_in_t [NPORTS-1:0] gci_in,
  output wire gci_out_t [NPORTS-1:0] gci_out
);

  // Maps one route entry, the processor byte and the source byte to the
  // byte that goes out on the link.
  function automatic logic [7:0] route_byte(
    input route_t e,
    input logic [1:0] kind,
    input logic [7:0] cpu,
    input logic [7:0] src,
    input logic wake
  );
    logic [7:0] m;
    logic [7:0] b;
    m = (e.fmask[2] ? D_MASK : '0) | (e.fmask[1] ? CI_MASK : '0) | (e.fmask[0] ? HS_MASK : '0);
    case (e.mode)
      RM_ROUTE: b = (kind == BYTE_DCI) ? ((src & m) | (cpu & ~m)) : src; // RULE_03
      RM_IDLE: b = IDLE_BYTE; // RULE_04
      default: b = cpu;
    endcase
    // The wake code overrides C/I so the line side starts its timing only.
    if (wake && kind == BYTE_DCI && e.mode != RM_IDLE) begin
      b[CI_LSB +: CI_W] = WAKE_CODE; // RULE_12
    end
    route_byte = b;
  endfunction : route_byte

  // Frame images and routing state in the bus domain.
  logic [7:0] rx_mem [NPORTS][NBYTES];
  logic [7:0] tx_mem [NPORTS][NBYTES];
  route_t route_tab [NPORTS][NBYTES];
  port_cfg_t cfg [NPORTS];
  logic [7:0] frame_cnt [NPORTS];

  // Signals that cross between the domains.
  link_req_t req_l [NPORTS];
  logic [NPORTS-1:0] req_tgl;
  logic [NPORTS-1:0] req_s1;
  logic [NPORTS-1:0] req_s2;
  logic [NPORTS-1:0] req_s3;
  logic [NPORTS-1:0] lock_l;
  logic [NPORTS-1:0] lock_s1;
  logic [NPORTS-1:0] lock_s2;
  logic [NPORTS-1:0] ack_tgl;
  logic [7:0] ack_byte [NPORTS];
  logic [7:0] tx_calc [NPORTS];

  // A toggle seen after the second flop marks a finished link byte.
  wire logic [NPORTS-1:0] req_ev = req_s2 ^ req_s3;

  // One link engine per port; all three are built alike.
  for (genvar p = 0; p < NPORTS; p++) begin : g_port // RULE_01
    wire logic [IDX_W-1:0] ti = req_l[p].tx_idx;
    wire route_t ent = route_tab[p][ti];
    wire logic [1:0] kind = ti[1:0];
    wire logic is_b = (kind == BYTE_B1) || (kind == BYTE_B2);
    // B bytes may pick either source B byte; other fields keep their role.
    wire logic [1:0] skind = is_b ? {1'b0, ent.src_b} : kind; // RULE_13
    wire logic [IDX_W-1:0] si = {ent.src_slot, skind};
    wire logic src_ok = ent.src_port < PORT_LIMIT;
    wire logic [7:0] src = src_ok ? rx_mem[ent.src_port][si] : IDLE_BYTE;

    assign tx_calc[p] = route_byte(ent, kind, tx_mem[p][ti], src, cfg[p].wake); // RULE_03

    gci_port_link u_link (
      .link_clk(link_clk),
      .presetn(presetn),
      .pin_in(gci_in[p]),
      .ref_fsc(line_ref_fsc), // RULE_11
      .pin_out(gci_out[p]),
      .cfg(cfg[p]),
      .ack_byte(ack_byte[p]),
      .ack_tgl(ack_tgl[p]),
      .req(req_l[p]),
      .req_tgl(req_tgl[p]),
      .locked(lock_l[p])
    );
  end

  // Synchronisers for the request toggles and the lock levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_s1 <= '0;
      req_s2 <= '0;
      req_s3 <= '0;
      lock_s1 <= '0;
      lock_s2 <= '0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      lock_s1 <= lock_l;
      lock_s2 <= lock_s1;
    end
  end

  // Service of finished link bytes: store the received byte and answer
  // with the byte two positions ahead. The request data is held for a
  // whole byte time, far longer than the three-flop detection delay.
  // Routes therefore run every frame with no processor action.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NPORTS; p++) begin
        for (int i = 0; i < NBYTES; i++) begin
          rx_mem[p][i] <= IDLE_BYTE;
        end
        ack_byte[p] <= IDLE_BYTE;
        frame_cnt[p] <= '0;
      end
      ack_tgl <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (req_ev[p]) begin
          rx_mem[p][req_l[p].rx_idx] <= req_l[p].rx_byte; // RULE_02
          ack_byte[p] <= tx_calc[p]; // RULE_05
          ack_tgl[p] <= ~ack_tgl[p];
          if (req_l[p].rx_idx == '0) begin
            frame_cnt[p] <= frame_cnt[p] + 1'b1;
          end
        end
      end
    end
  end

  // Address decode: port, region and word index.
  wire logic [PORT_W-1:0] a_port = paddr[PORT_LSB +: PORT_W];
  wire logic [REGION_W-1:0] a_reg = paddr[REGION_LSB +: REGION_W];
  wire logic [IDX_W-1:0] a_idx = paddr[IDX_LSB +: IDX_W];
  wire logic a_ok = (a_port < PORT_LIMIT) & ~paddr[IDX_TOP];
  wire logic hit_rx = a_ok & (a_reg == REG_RX);
  wire logic hit_tx = a_ok & (a_reg == REG_TX);
  wire logic hit_rt = a_ok & (a_reg == REG_ROUTE);
  wire logic hit_ctrl = a_ok & (a_reg == REG_CTRL) & (a_idx == CTRL_IDX);
  wire logic hit_stat = a_ok & (a_reg == REG_CTRL) & (a_idx == STAT_IDX);
  wire logic rd_hit = hit_rx | hit_tx | hit_rt | hit_ctrl | hit_stat;
  // Received bytes and status are read-only; writing them is an error.
  wire logic wr_hit = hit_tx | hit_rt | hit_ctrl;

  // Status word: lock state and a count of frames seen.
  wire stat_t stat_word = '{frame_cnt[a_port], '0, lock_s2[a_port]};

  // Read selection; unmapped words read as zero.
  wire logic [DATA_W-1:0] rd_word =
    hit_rx ? DATA_W'(rx_mem[a_port][a_idx]) : // RULE_02
    hit_tx ? DATA_W'(tx_mem[a_port][a_idx]) :
    hit_rt ? DATA_W'(route_tab[a_port][a_idx]) :
    hit_ctrl ? DATA_W'(cfg[a_port]) :
    hit_stat ? DATA_W'(stat_word) : '0;

  // Every transfer takes one wait state so the array reads have a cycle.
  wire logic access = psel & penable;
  wire logic wr_fire = access & pready & pwrite & wr_hit;

  // APB answer: ready, data and error all come from flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= access & ~pready;
      if (access & ~pready) begin
        prdata <= pwrite ? '0 : rd_word;
        pslverr <= pwrite ? ~wr_hit : ~rd_hit;
      end
    end
  end

  // Register writes land at the edge that completes the transfer.
  // Outgoing bytes start idle and every route starts as processor data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NPORTS; p++) begin
        for (int i = 0; i < NBYTES; i++) begin
          tx_mem[p][i] <= IDLE_BYTE;
          route_tab[p][i] <= '0;
        end
        cfg[p] <= '0;
      end
    end else if (wr_fire) begin
      if (hit_tx) begin
        tx_mem[a_port][a_idx] <= pwdata[7:0]; // RULE_02
      end
      if (hit_rt) begin
        route_tab[a_port][a_idx] <= route_t'(pwdata[$bits(route_t)-1:0]); // RULE_03
      end
      if (hit_ctrl) begin
        cfg[a_port] <= port_cfg_t'(pwdata[$bits(port_cfg_t)-1:0]); // RULE_08
      end
    end
  end

endmodule : tri_port_gci_router
`default_nettype wire

// >>> verification/gci_router_properties.sv
`timescale 1ns/100ps
`default_nettype none
module gci_router_properties
  import gci_router_pkg::*;
(
  // Clocks and reset
  input wire logic pclk,
  input wire logic link_clk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pslverr,
  // Port pins
  input wire gci_out_t [NPORTS-1:0] gci_out
);
  // Address decode, kept apart so the properties stay short.
  wire bad_port = paddr[12:11] == 2'h3;
  wire [2:0] region = paddr[10:8];
  // A transfer is a setup cycle followed by an access cycle.
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && !pready;
  endsequence
  // Bus answers come after exactly one wait state and last one cycle.
  AST_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    setup_s ##1 access_s |=> pready) else $error("ready not one wait state");
  AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pready) |=> !pready) else $error("ready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> psel && penable && $past(psel && penable)) else $error("ready outside access");
  // Refusals: only three ports exist, received bytes are read-only.
  AST_BAD_PORT: assert property (@(posedge pclk) disable iff (!presetn)
    pready && bad_port && !pwrite |-> pslverr && prdata == 32'h0) else $error("fourth port answered");
  AST_RX_READONLY: assert property (@(posedge pclk) disable iff (!presetn)
    pready && pwrite && !bad_port && region == REG_RX |-> pslverr) else $error("rx write accepted");
  AST_BYTE_WORD: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && !bad_port && !paddr[7] && region == REG_TX |-> !pslverr && prdata[31:8] == 24'h0)
    else $error("tx byte read wrong");
  // Pins are checked on every port, since all three are built alike.
  for (genvar p = 0; p < NPORTS; p++) begin : g_pin
    AST_OPEN_DRAIN: assert property (@(posedge link_clk) disable iff (!presetn)
      gci_out[p].dout_oe_n == gci_out[p].dout) else $error("data pin driven high");
    AST_FSC_GAP: assert property (@(posedge link_clk) disable iff (!presetn)
      gci_out[p].fsc |=> !gci_out[p].fsc [*8]) else $error("frame sync too long");
    AST_FSC_DRIVEN: assert property (@(posedge link_clk) disable iff (!presetn)
      gci_out[p].fsc |-> !gci_out[p].fsc_oe_n) else $error("frame sync not driven");
  end
endmodule : gci_router_properties
`default_nettype wire

// >>> verification/gci_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module gci_far_end
  import gci_router_pkg::*;
#(
  parameter int SLOTS = 1,
  parameter logic [7:0] SEED = 8'h00,
  parameter logic MASTER = 1'b1
) (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic presetn,
  // Router port pins
  input wire gci_out_t pin_out,
  output var gci_in_t pin_in
);
  localparam logic [7:0] LAST = 8'(SLOTS * 32 - 1);
  logic [7:0] pos;
  logic [7:0] cap;
  logic [7:0] seen [0:31];
  int frames;
  // The data line has a pull-up, so a released output reads as one.
  wire line = pin_out.dout_oe_n ? 1'b1 : 1'b0;
  wire [7:0] next_pos = (pos == LAST) ? 8'h00 : pos + 8'h01;
  wire [7:0] lag_pos = (pos < 8'h02) ? pos + LAST - 8'h01 : pos - 8'h02;
  wire [7:0] sent = {SEED[7:5], next_pos[7:3]};
  // Frame timing is mastered here; the router's pin flops put it two cycles behind us.
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      pos <= 8'h00;
      cap <= 8'h00;
      pin_in <= '0;
      frames <= 0;
    end else begin
      pos <= next_pos;
      pin_in.fsc <= MASTER && (next_pos == LAST);
      pin_in.din <= sent[3'h7 - next_pos[2:0]];
      cap <= {cap[6:0], line};
      if (lag_pos[2:0] == 3'h7) begin
        seen[lag_pos[7:3]] <= {cap[6:0], line};
      end
      if (pos == 8'h00) begin
        frames <= frames + 1;
      end
    end
  end
endmodule : gci_far_end
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench import gci_router_pkg::*;;
  typedef struct packed {
    logic [4:0] idx;
    route_mode_t mode;
    logic [1:0] sport;
    logic b;
    logic [2:0] mask;
    logic [7:0] tx;
    logic [7:0] exp;
  } route_case_t;
  // Port 1 byte plan: routes, idle bytes and processor bytes mixed.
  route_case_t plan [10] = '{
    '{5'h00, RM_ROUTE, 2'h0, 1'b0, 3'h0, 8'h00, 8'ha0},
    '{5'h01, RM_ROUTE, 2'h0, 1'b0, 3'h0, 8'h00, 8'ha0},
    '{5'h04, RM_ROUTE, 2'h0, 1'b1, 3'h0, 8'h00, 8'ha1},
    '{5'h02, RM_IDLE, 2'h0, 1'b0, 3'h0, 8'h00, 8'hff},
    '{5'h03, RM_ROUTE, 2'h0, 1'b0, 3'h7, 8'h00, 8'ha3},
    '{5'h06, RM_ROUTE, 2'h0, 1'b0, 3'h0, 8'h00, 8'ha2},
    '{5'h07, RM_ROUTE, 2'h0, 1'b0, 3'h0, 8'h5a, 8'h5a},
    '{5'h05, RM_SPARE, 2'h0, 1'b0, 3'h0, 8'h99, 8'h99},
    '{5'h1c, RM_ROUTE, 2'h3, 1'b0, 3'h0, 8'h00, 8'hff},
    '{5'h1f, RM_CPU, 2'h0, 1'b0, 3'h0, 8'h3c, 8'h3c}};
  logic pclk = 1'b0;
  logic link_clk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [PADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  wire gci_in_t [NPORTS-1:0] gci_in;
  wire gci_out_t [NPORTS-1:0] gci_out;
  wire logic line_ref_fsc = gci_in[0].fsc;
  int error_cnt = 0;
  int num_checks = 0;
  // Two unrelated clocks: bus at 4 ns, link at 30 ns.
  always #2 pclk = ~pclk;
  always #15 link_clk = ~link_clk;
  tri_port_gci_router u_tri_port_gci_router (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .link_clk(link_clk), .line_ref_fsc(line_ref_fsc), .gci_in(gci_in), .gci_out(gci_out));
  // Port 2 runs on internal timing, so its far end is a timing slave.
  gci_far_end #(.SEED(8'ha0)) u_far0 (.link_clk(link_clk), .presetn(presetn),
    .pin_out(gci_out[0]), .pin_in(gci_in[0]));
  gci_far_end #(.SLOTS(8), .SEED(8'h40)) u_far1 (.link_clk(link_clk), .presetn(presetn),
    .pin_out(gci_out[1]), .pin_in(gci_in[1]));
  gci_far_end #(.SEED(8'h60), .MASTER(1'b0)) u_far2 (.link_clk(link_clk), .presetn(presetn),
    .pin_out(gci_out[2]), .pin_in(gci_in[2]));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [1:0] p, input logic [2:0] r, input logic [4:0] i,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {p, r, 1'b0, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, {31'h0, pready});
      end_of_test();
    end
  endtask : apb
  task automatic rchk(input string what, input logic [1:0] p, input logic [2:0] r, input logic [4:0] i,
      input logic [31:0] exp, input logic eerr);
    apb(1'b0, p, r, i, 32'h0);
    chk(what, exp, rd);
    chk(what, {31'h0, eerr}, {31'h0, err});
  endtask : rchk
  // Waits on the far end's frame count, never a fixed delay.
  task automatic wait_frames(input int n);
    int start, k;
    start = u_far1.frames;
    k = 0;
    while (u_far1.frames < start + n && k < 40000) begin
      @(posedge pclk);
      k++;
    end
    chk("frame count", 32'h1, {31'h0, u_far1.frames >= start + n});
  endtask : wait_frames
  task automatic fsc_period(input int exp);
    int n;
    for (int j = 0; j < 2; j++) begin
      n = 0;
      do begin
        @(posedge link_clk);
        n++;
      end while (gci_out[2].fsc !== 1'b1 && n < 600);
    end
    chk("frame length", 32'(exp), 32'(n));
  endtask : fsc_period
  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (4) @(posedge link_clk);
    @(posedge pclk);
    presetn <= 1'b1;
    rchk("tx reset", 2'h1, REG_TX, 5'h1f, 32'hff, 1'b0);
    rchk("ctrl reset", 2'h2, REG_CTRL, CTRL_IDX, 32'h0, 1'b0);
    rchk("route reset", 2'h1, REG_ROUTE, 5'h00, 32'h0, 1'b0);
    rchk("port three", 2'h3, REG_TX, 5'h00, 32'h0, 1'b1);
    rchk("region four", 2'h0, 3'h4, 5'h00, 32'h0, 1'b1);
    rchk("ctrl index two", 2'h0, REG_CTRL, 5'h02, 32'h0, 1'b1);
    apb(1'b1, 2'h0, REG_RX, 5'h00, 32'h55);
    chk("rx write refused", 32'h1, {31'h0, err});
    apb(1'b1, 2'h1, REG_CTRL, CTRL_IDX, 32'h07);
    rchk("ctrl readback", 2'h1, REG_CTRL, CTRL_IDX, 32'h07, 1'b0);
    foreach (plan[c]) begin
      apb(1'b1, 2'h1, REG_TX, plan[c].idx, {24'h0, plan[c].tx});
      apb(1'b1, 2'h1, REG_ROUTE, plan[c].idx,
        {20'h0, plan[c].mode, plan[c].sport, 3'h0, plan[c].b, plan[c].mask, 1'b0});
    end
    apb(1'b1, 2'h0, REG_CTRL, CTRL_IDX, 32'h20);
    wait_frames(4);
    foreach (plan[c]) chk("routed byte", {24'h0, plan[c].exp}, {24'h0, u_far1.seen[plan[c].idx]});
    chk("wake c/i", {24'h0, (IDLE_BYTE & ~CI_MASK) | {WAKE_CODE_DEF, 2'b00}}, {24'h0, u_far0.seen[3]});
    rchk("rx monitor", 2'h0, REG_RX, 5'h02, 32'ha2, 1'b0);
    rchk("rx last byte", 2'h1, REG_RX, 5'h1f, 32'h5f, 1'b0);
    rchk("tx readback", 2'h1, REG_TX, 5'h07, 32'h5a, 1'b0);
    apb(1'b1, 2'h2, REG_CTRL, CTRL_IDX, 32'h08);
    wait_frames(1);
    fsc_period(32);
    apb(1'b1, 2'h2, REG_CTRL, CTRL_IDX, 32'h09);
    wait_frames(1);
    fsc_period(256);
    apb(1'b1, 2'h2, REG_CTRL, CTRL_IDX, 32'h18);
    wait_frames(2);
    apb(1'b0, 2'h2, REG_CTRL, STAT_IDX, 32'h0);
    chk("locked", 32'h1, rd & 32'h1);
    end_of_test();
  end
endmodule : testbench
bind tri_port_gci_router gci_router_properties u_props (.pclk(pclk), .link_clk(link_clk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .gci_out(gci_out));
`default_nettype wire
